// ---- timer_pkg.sv ----
package timer_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] addr_a_control     = 8'h18;
    localparam logic [7:0] addr_b_control     = 8'h1c;
    localparam logic [7:0] addr_a_period      = 8'h20;
    localparam logic [7:0] addr_a_pulse_width = 8'h24;
    localparam logic [7:0] addr_b_period      = 8'h28;
    localparam logic [7:0] addr_b_pulse_width = 8'h2c;
    localparam logic [7:0] addr_config        = 8'h30;
    localparam logic [7:0] addr_status        = 8'h34;

    localparam logic [7:0]  control_reset = 8'h00;
    localparam logic [7:0]  data_reset    = 8'h00;
    localparam logic [31:0] zero_word     = 32'h0000_0000;

    // ------------------------------------------------------------
    // clock select and mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] clk_slowest = 3'h0;
    localparam logic [2:0] clk_div7    = 3'h1;
    localparam logic [2:0] clk_div5    = 3'h2;
    localparam logic [2:0] clk_div3    = 3'h3;
    localparam logic [2:0] clk_low     = 3'h4;
    localparam logic [2:0] clk_half    = 3'h5;
    localparam logic [2:0] clk_full    = 3'h6;
    localparam logic [2:0] clk_pin     = 3'h7;

    localparam logic [2:0] mode_timer8 = 3'h0;
    localparam logic [2:0] mode_divout8 = 3'h1;
    localparam logic [2:0] mode_pwm8   = 3'h2;
    localparam logic [2:0] mode_16bit  = 3'h3;
    localparam logic [2:0] mode_timer16 = 3'h4;
    localparam logic [2:0] mode_warmup = 3'h5;
    localparam logic [2:0] mode_pwm16  = 3'h6;
    localparam logic [2:0] mode_ppg16  = 3'h7;

    // divider tap positions
    localparam int tap_11 = 11;
    localparam int tap_7  = 7;
    localparam int tap_5  = 5;
    localparam int tap_3  = 3;
    localparam int tap_1  = 1;
    localparam int low_tap = 3;
    localparam int div_width = 12;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       flipflop_init;
        logic [2:0] clock_select;
        logic       run;
        logic [2:0] mode_select;
    } control_type;

    typedef struct packed {
        logic       sel;
        logic       write;
        logic [7:0] addr;
    } bus_req_type;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_run  = 2'b01
    } run_state_type;

endpackage

// ---- tap_select.sv ----
`timescale 1ns/10ps
`default_nettype none
module tap_select
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // source choice
    input  wire logic [2:0]           clock_select,
    input  wire logic                 divider_seven_source,
    input  wire logic                 slow_mode,
    input  wire logic [div_width-1:0] div_rise,
    input  wire logic                 low_tick,
    input  wire logic                 pin_rise,
    // selected tick
    output logic                      tick
);
    logic tick_next;

    always_comb begin
        case (clock_select)
            clk_slowest: tick_next = (divider_seven_source || slow_mode) ? low_tick
                                                                          : div_rise[tap_11];
            clk_div7:    tick_next = div_rise[tap_7] && !slow_mode;
            clk_div5:    tick_next = div_rise[tap_5] && !slow_mode;
            clk_div3:    tick_next = div_rise[tap_3] && !slow_mode;
            clk_low:     tick_next = low_tick;
            clk_half:    tick_next = div_rise[tap_1] && !slow_mode;
            clk_full:    tick_next = 1'b1;
            default:     tick_next = pin_rise;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 1'b0;
        end else begin
            tick <= tick_next;
        end
    end
endmodule
`default_nettype wire

// ---- dual_timer_control.sv ----
// What this block does
// - timer_a_control is an 8-bit read/write register at 0018H, reset to zero.
// - clock select picks divider tap, low clock, high clock, or external pin.
// - clearing run stops and zeroes the count; setting run starts counting.
// - timer A mode: 8-bit timer, divider output, PWM, or 16-bit cascade.
// - in 16-bit, A clock select drives; B run and B flip-flop bit rule.
// - each unit has control, period and pulse-width registers.
// - pulse width rewritable while running only in PWM modes.
// - timer B modes 100 timer, 101 warm-up, 110 PWM, 111 pulse generator.
// - in 16-bit, timer B mode 1xx counts timer A overflow, ignoring its clock select.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module dual_timer_control
    import timer_pkg::*;
(
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // count sources
    input  wire logic        low_freq_clock,
    input  wire logic        timer_a_pin,
    input  wire logic        timer_b_pin,
    // state seen by the outside
    output logic [7:0]       timer_a_count,
    output logic [7:0]       timer_b_count,
    output logic             timer_a_flipflop,
    output logic             timer_b_flipflop,
    output logic             timer_a_running,
    output logic             timer_b_running
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    control_type  ctl_a_reg, ctl_a_next, ctl_b_reg, ctl_b_next;
    logic [7:0]   per_a_reg, per_a_next, pw_a_reg, pw_a_next;
    logic [7:0]   per_b_reg, per_b_next, pw_b_reg, pw_b_next;
    logic [1:0]   cfg_reg, cfg_next;
    bus_req_type  req_reg, req_next;
    logic [31:0]  rdata_next;
    logic         wr_a_ctl;

    wire logic divider_seven_source = cfg_reg[0];
    wire logic slow_mode            = cfg_reg[1];
    wire logic cascade = (ctl_a_reg.mode_select == mode_16bit);
    wire logic b_upper = ctl_b_reg.mode_select[2];
    // in cascade timer B's run, flip-flop and mode bits stand in for timer A's
    wire control_type eff_a = cascade ? ctl_b_reg : ctl_a_reg;

    always_comb begin
        req_next = req_reg;
        if (hready) begin
            req_next.sel   = hsel && htrans[1];
            req_next.write = hwrite;
            req_next.addr  = haddr[7:0];
        end
    end

    function automatic logic pw_writable(input control_type c, input logic casc);
        pw_writable = !c.run || c.mode_select == mode_pwm8
                      || (casc && c.mode_select == mode_pwm16);
    endfunction

    always_comb begin
        ctl_a_next = ctl_a_reg;
        ctl_b_next = ctl_b_reg;
        per_a_next = per_a_reg;
        per_b_next = per_b_reg;
        pw_a_next  = pw_a_reg;
        pw_b_next  = pw_b_reg;
        cfg_next   = cfg_reg;
        wr_a_ctl   = 1'b0;
        if (req_reg.sel && req_reg.write) begin
            case (req_reg.addr)
                addr_a_control: begin
                    ctl_a_next = hwdata[7:0];
                    wr_a_ctl   = 1'b1;
                end
                addr_b_control:     ctl_b_next = hwdata[7:0];
                addr_a_period:      per_a_next = hwdata[7:0];
                addr_b_period:      per_b_next = hwdata[7:0];
                addr_a_pulse_width: begin
                    if (pw_writable(eff_a, cascade)) begin
                        pw_a_next = hwdata[7:0];
                    end
                end
                addr_b_pulse_width: begin
                    if (pw_writable(ctl_b_reg, cascade)) begin
                        pw_b_next = hwdata[7:0];
                    end
                end
                addr_config: cfg_next = hwdata[1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_next = zero_word;
        if (req_next.sel && !req_next.write) begin
            case (req_next.addr)
                addr_a_control:     rdata_next[7:0] = ctl_a_next;
                addr_b_control:     rdata_next[7:0] = ctl_b_next;
                addr_a_period:      rdata_next[7:0] = per_a_next;
                addr_a_pulse_width: rdata_next[7:0] = pw_a_next;
                addr_b_period:      rdata_next[7:0] = per_b_next;
                addr_b_pulse_width: rdata_next[7:0] = pw_b_next;
                addr_config:        rdata_next[1:0] = cfg_next;
                addr_status:        rdata_next[3:0] = {timer_b_flipflop, timer_a_flipflop,
                                                       timer_b_running, timer_a_running};
                default:            rdata_next = zero_word;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_a_reg <= control_reset;
            ctl_b_reg <= control_reset;
            per_a_reg <= data_reset;
            per_b_reg <= data_reset;
            pw_a_reg  <= data_reset;
            pw_b_reg  <= data_reset;
            cfg_reg   <= 2'h0;
            req_reg   <= '0;
            hrdata    <= zero_word;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ctl_a_reg <= ctl_a_next;
            ctl_b_reg <= ctl_b_next;
            per_a_reg <= per_a_next;
            per_b_reg <= per_b_next;
            pw_a_reg  <= pw_a_next;
            pw_b_reg  <= pw_b_next;
            cfg_reg   <= cfg_next;
            req_reg   <= req_next;
            hrdata    <= rdata_next;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // prescaler and input synchronisers
    // ------------------------------------------------------------
    logic [div_width-1:0] div_reg, div_next;
    logic [div_width-1:0] div_rise;
    logic [2:0] low_sync_reg, a_sync_reg, b_sync_reg;
    logic [low_tap-1:0] low_div_reg, low_div_next;
    logic low_tick_raw, low_edge;

    always_comb begin
        div_next     = div_reg + 1'b1;
        div_rise     = div_next ^ div_reg; // bit n toggles once every 2^n cycles
        low_edge     = low_sync_reg[1] && !low_sync_reg[2];
        low_div_next = low_edge ? low_div_reg + 1'b1 : low_div_reg;
        low_tick_raw = low_edge;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg      <= '0;
            low_div_reg  <= '0;
            low_sync_reg <= 3'h0;
            a_sync_reg   <= 3'h0;
            b_sync_reg   <= 3'h0;
        end else begin
            div_reg      <= div_next;
            low_div_reg  <= low_div_next;
            low_sync_reg <= {low_sync_reg[1:0], low_freq_clock};
            a_sync_reg   <= {a_sync_reg[1:0], timer_a_pin};
            b_sync_reg   <= {b_sync_reg[1:0], timer_b_pin};
        end
    end

    // low clock divided by 2^3 for the slowest tap
    wire logic low_slow_tick = low_edge && (low_div_reg[low_tap-1:0] == '1);
    logic tick_a, tick_b_own;
    tap_select tap_a (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .clock_select         (ctl_a_reg.clock_select),
        .divider_seven_source (divider_seven_source),
        .slow_mode            (slow_mode),
        .div_rise             (div_rise),
        .low_tick             (ctl_a_reg.clock_select == clk_slowest ? low_slow_tick
                                                                     : low_tick_raw),
        .pin_rise             (a_sync_reg[1] && !a_sync_reg[2]),
        .tick                 (tick_a)
    );

    tap_select tap_b (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .clock_select         (ctl_b_reg.clock_select),
        .divider_seven_source (divider_seven_source),
        .slow_mode            (slow_mode),
        .div_rise             (div_rise),
        .low_tick             (ctl_b_reg.clock_select == clk_slowest ? low_slow_tick
                                                                     : low_tick_raw),
        .pin_rise             (b_sync_reg[1] && !b_sync_reg[2]),
        .tick                 (tick_b_own)
    );

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    logic [7:0] cnt_a_next, cnt_b_next;
    logic       ff_a_next, ff_b_next;
    logic       run_a, run_b, ovf_a, tick_b;

    always_comb begin
        run_a  = eff_a.run;
        run_b  = ctl_b_reg.run;
        ovf_a  = run_a && tick_a && (timer_a_count == 8'hff);
        tick_b = (cascade && b_upper) ? ovf_a : tick_b_own;
        cnt_a_next = timer_a_count;
        cnt_b_next = timer_b_count;
        ff_a_next  = timer_a_flipflop;
        ff_b_next  = timer_b_flipflop;
        if (!run_a) begin
            cnt_a_next = 8'h00;
            ff_a_next  = eff_a.flipflop_init;
        end else if (tick_a) begin
            cnt_a_next = timer_a_count + 8'h01;
        end
        if (!run_b) begin
            cnt_b_next = 8'h00;
            ff_b_next  = ctl_b_reg.flipflop_init;
        end else if (tick_b) begin
            cnt_b_next = timer_b_count + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_a_count    <= 8'h00;
            timer_b_count    <= 8'h00;
            timer_a_flipflop <= 1'b0;
            timer_b_flipflop <= 1'b0;
            timer_a_running  <= 1'b0;
            timer_b_running  <= 1'b0;
        end else begin
            timer_a_count    <= cnt_a_next;
            timer_b_count    <= cnt_b_next;
            timer_a_flipflop <= ff_a_next;
            timer_b_flipflop <= ff_b_next;
            timer_a_running  <= run_a;
            timer_b_running  <= run_b;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence full_held_s;
        ctl_a_reg.clock_select == clk_full ##1 ctl_a_reg.clock_select == clk_full;
    endsequence
    stop_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !run_a |=> timer_a_count == 8'h00) else $error("count a not cleared");
    stop_clears_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !run_b |=> timer_b_count == 8'h00) else $error("count b not cleared");
    ctl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_a_ctl |=> ctl_a_reg == $past(hwdata[7:0])) else $error("ctl a write lost");
    pw_guard_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl_a_reg.run && ctl_a_reg.mode_select == mode_timer8 |=> $stable(pw_a_reg))
        else $error("pw a changed while running");
    cascade_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cascade |=> timer_a_running == $past(ctl_b_reg.run)) else $error("cascade run wrong");
    upper_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cascade && b_upper && run_b |=> timer_b_count == $past(timer_b_count) + 8'($past(ovf_a)))
        else $error("upper tick wrong");
    count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run_a && tick_a |=> timer_a_count == $past(timer_a_count) + 8'h01)
        else $error("count a step");
    full_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
        full_held_s |-> tick_a) else $error("full clock tick missing");
    run_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl_a_reg.run && !cascade |=> timer_a_running) else $error("running flag");
endmodule
`default_nettype wire

// ---- dual_timer_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module dual_timer_control_tb
    import timer_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        lowc = 1'b0;
    logic        pa = 1'b0;
    logic        pb = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  ca;
    logic [7:0]  cb;
    logic        ffa;
    logic        ffb;
    logic        runa;
    logic        runb;
    int          errors = 0;
    int          comparisons = 0;
    logic [7:0]  c1;
    logic [7:0]  c2;

    localparam logic [7:0] al [9] = '{addr_a_control, addr_b_control, addr_a_period,
        addr_a_pulse_width, addr_b_period, addr_b_pulse_width, addr_config, addr_status, 8'h40};
    localparam int cyc [8] = '{16384, 1024, 256, 64, 5, 8, 8, 5};
    localparam int rate [8] = '{8, 8, 8, 8, 5, 4, 8, 5};

    always #20 hclk = ~hclk;

    dual_timer_control dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .low_freq_clock(lowc), .timer_a_pin(pa), .timer_b_pin(pb),
        .timer_a_count(ca), .timer_b_count(cb), .timer_a_flipflop(ffa),
        .timer_b_flipflop(ffb), .timer_a_running(runa), .timer_b_running(runb)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("response", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check($sformatf("register %h", a), r, e);
    endtask

    // pin selects the external pin, otherwise the low clock
    task automatic edges(input int n, input bit pin);
        repeat (n) begin
            if (pin) pa <= 1'b1;
            else lowc <= 1'b1;
            tick(4);
            if (pin) pa <= 1'b0;
            else lowc <= 1'b0;
            tick(8);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge hclk);
        errors++;
        $display("watchdog expired");
        final_report;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        tick(16);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 9; i++) begin
            rd(al[i], 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            wr(al[i], 32'hffff_ffa7);
            rd(al[i], 32'ha7);
        end
        wr(8'h40, 32'h55);
        rd(8'h40, 32'h0);
        for (int m = 0; m < 8; m++) begin
            wr(m < 4 ? addr_a_control : addr_b_control, {29'h0, 3'(m)});
            rd(m < 4 ? addr_a_control : addr_b_control, {29'h0, 3'(m)});
        end
        wr(addr_a_control, 32'h0);
        wr(addr_b_control, 32'h0);
        $display("test registers done");

        wr(addr_a_control, 32'he8);
        tick(10);
        check("running", {31'h0, runa}, 32'h1);
        check("counting", {31'h0, ca != 8'h0}, 32'h1);
        wr(addr_a_control, 32'he0);
        tick(3);
        check("count", {24'h0, ca}, 32'h0);
        check("running", {31'h0, runa}, 32'h0);
        check("flipflop", {31'h0, ffa}, 32'h1);
        wr(addr_a_control, 32'h0);
        $display("test run done");

        for (int s = 0; s < 8; s++) begin
            wr(addr_a_control, {24'h0, 1'b0, 3'(s), 1'b1, mode_timer8});
            tick(16);
            c1 = ca;
            if (s == 4 || s == 7) edges(cyc[s], s == 7);
            else tick(cyc[s]);
            c2 = ca;
            check($sformatf("rate %0d", s), {24'h0, c2 - c1}, rate[s]);
            wr(addr_a_control, {24'h0, 1'b0, 3'(s), 1'b0, mode_timer8});
        end
        for (int k = 1; k < 3; k++) begin
            wr(addr_config, k);
            wr(addr_a_control, {24'h0, 1'b0, 3'(k - 1), 1'b1, mode_timer8});
            tick(16);
            c1 = ca;
            if (k == 1) edges(16, 1'b0);
            else tick(1024);
            c2 = ca;
            check("slow rate", {24'h0, c2 - c1}, k == 1 ? 2 : 0);
            wr(addr_a_control, {24'h0, 1'b0, 3'(k - 1), 1'b0, mode_timer8});
        end
        wr(addr_config, 32'h0);
        $display("test clock select done");

        wr(addr_a_pulse_width, 32'h11);
        wr(addr_a_control, 32'h68);
        wr(addr_a_pulse_width, 32'h22);
        rd(addr_a_pulse_width, 32'h11);
        rd(addr_status, 32'h1);
        wr(addr_a_control, 32'h60);
        wr(addr_a_control, 32'h6a);
        wr(addr_a_pulse_width, 32'h33);
        rd(addr_a_pulse_width, 32'h33);
        wr(addr_a_control, 32'h62);
        $display("test pulse width done");

        wr(addr_a_control, 32'h63);
        wr(addr_b_control, 32'h84);
        tick(3);
        check("cascade flipflop", {30'h0, ffa, ffb}, 32'h3);
        wr(addr_b_control, 32'h8c);
        tick(3);
        check("cascade run", {30'h0, runa, runb}, 32'h3);
        wr(addr_a_pulse_width, 32'h44);
        wr(addr_b_pulse_width, 32'h44);
        rd(addr_a_pulse_width, 32'h33);
        rd(addr_b_pulse_width, 32'ha7);
        c1 = cb;
        tick(512);
        c2 = cb;
        check("cascade rate", {24'h0, c2 - c1}, 32'h2);
        wr(addr_b_control, 32'h84);
        tick(3);
        check("cascade stop", {16'h0, ca, cb}, 32'h0);
        $display("test cascade done");
        final_report;
    end
endmodule
`default_nettype wire
